// ==== include/swu_consts.svh ====
// constants of the single-wire serial node and its configuration register
`ifndef SWU_CONSTS_SVH
`define SWU_CONSTS_SVH
`define SWU_REG_GLOBAL_CFG 7'h00
`define SWU_REG_WRITE_COUNT 7'h02
`define SWU_REG_REPLY_DELAY 7'h03
`define SWU_WRITE_OFFSET 8'h80
`define SWU_NODE_ADDR 8'h00
`define SWU_MASTER_ADDR 8'hFF
`define SWU_SYNC_BYTE 8'h05
`define SWU_SYNC_FIRST_BIT 3'h3
`define SWU_GLOBAL_CFG_RESET 10'h101
`define SWU_REPLY_DELAY_RESET 4'h0
`define SWU_WRITE_COUNT_RESET 8'h00
`define SWU_DLY_LSB 8
`define SWU_DLY_MSB 11
`define SWU_CRC_POLY 8'h07
`define SWU_LAST_WRITE 3'h7
`define SWU_LAST_READ 3'h3
`define SWU_LAST_REPLY 3'h7
`define SWU_RELEASE_BITS 7'h04
`define SWU_RECOVER_BITS 7'h0C
`define SWU_MIN_BIT_CLKS 16'h0010
`define SWU_DEFAULT_BIT_CLKS 16'h08AE
`define SWU_GAP_SHIFT 6
`endif

// ==== include/swu_pkg.sv ====
// types of the single-wire serial node
package swu_pkg;
	typedef struct packed {
		logic analog_test_enable;
		logic step_filter_enable;
		logic resolution_from_register;
		logic pin_standby_disable;
		logic index_shows_step;
		logic index_shows_prewarning;
		logic shaft_invert;
		logic chopper_mode_select;
		logic internal_sense_resistor_select;
		logic external_reference_select;
	} swu_global_cfg_t;

	typedef struct packed {
		logic external_reference;
		logic internal_sense;
		logic reference_pin_to_ground;
		logic cycle_chopper;
		logic motor_dir;
		logic standstill_from_pin;
		logic resolution_from_register;
		logic step_filter;
		logic analog_test;
		logic driver_forced_enable;
	} swu_drive_t;

	typedef enum logic [3:0] {
		LS_IDLE,
		LS_SYNC,
		LS_START,
		LS_BIT,
		LS_STOP,
		LS_GAP,
		LS_DELAY,
		LS_TX,
		LS_RELEASE,
		LS_RECOVER
	} swu_link_state_t;
endpackage

// ==== rtl/swu_cfg_apply.sv ====
// applies the global configuration bits to the driver control outputs
`timescale 1ns/10ps
module swu_cfg_apply (
	input wire logic clk,
	input wire logic resetn,
	input swu_pkg::swu_global_cfg_t cfg,
	input wire logic chopper_invert_pin,
	input wire logic dir_in,
	input wire logic pin_level,
	input wire logic first_microstep,
	input wire logic overtemp_prewarning,
	input wire logic pulse_gen_step,
	output swu_pkg::swu_drive_t drive,
	output logic index_out
);
	import swu_pkg::*;

	logic step_toggle;
	logic next_toggle;
	swu_drive_t next_drive;

	assign next_toggle = step_toggle ^ pulse_gen_step;

	always_comb
	begin
		next_drive.external_reference = cfg.external_reference_select;
		next_drive.internal_sense = cfg.internal_sense_resistor_select;
		next_drive.reference_pin_to_ground = cfg.internal_sense_resistor_select;
		next_drive.cycle_chopper = cfg.chopper_mode_select ^ chopper_invert_pin;
		next_drive.motor_dir = dir_in ^ cfg.shaft_invert;
		next_drive.standstill_from_pin = ~cfg.pin_standby_disable & pin_level;
		next_drive.resolution_from_register = cfg.resolution_from_register;
		next_drive.step_filter = cfg.step_filter_enable;
		next_drive.analog_test = cfg.analog_test_enable;
		next_drive.driver_forced_enable = cfg.analog_test_enable;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			drive <= '0;
		else
			drive <= next_drive;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			step_toggle <= 1'b0;
			index_out <= 1'b0;
		end
		else
		begin
			step_toggle <= next_toggle;
			if (cfg.index_shows_step)
				index_out <= next_toggle;
			else if (cfg.index_shows_prewarning)
				index_out <= overtemp_prewarning;
			else
				index_out <= first_microstep;
		end
	end
endmodule

// ==== rtl/swu_uart_node.sv ====
// single-wire half-duplex serial node with its register bank
`timescale 1ns/10ps
`include "swu_consts.svh"

module swu_uart_node (
	input wire logic clk,
	input wire logic resetn,
	input wire logic uart_in,
	output logic uart_out,
	output logic uart_oe,
	input wire logic otp_internal_sense,
	input wire logic otp_chopper_mode,
	input wire logic chopper_invert_pin,
	input wire logic dir_in,
	input wire logic first_microstep,
	input wire logic overtemp_prewarning,
	input wire logic pulse_gen_step,
	output swu_pkg::swu_drive_t drive,
	output logic index_out,
	output logic [7:0] datagram_count
);
	import swu_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [7:0] crc_byte(input logic [7:0] crc_in, input logic [7:0] data);
		logic [7:0] c;
		c = crc_in;
		for (int i = 0; i < 8; i++)
		begin
			if (c[7] ^ data[i])
				c = {c[6:0], 1'b0} ^ `SWU_CRC_POLY;
			else
				c = {c[6:0], 1'b0};
		end
		return c;
	endfunction

	function automatic logic [15:0] bit_wait(input logic [15:0] bt, input logic half);
		logic [15:0] w;
		w = half ? {1'b0, bt[15:1]} : bt;
		return w - 16'h0001;
	endfunction

	// ****************************************
	// state
	// ****************************************
	swu_link_state_t state;
	logic line_prev;
	logic fall;
	logic sync_edge;
	logic [15:0] bit_time;
	logic [15:0] cnt;
	logic [6:0] bcnt;
	logic [21:0] meas;
	logic [2:0] bit_idx;
	logic [2:0] byte_idx;
	logic [7:0] rx_byte;
	logic [7:0] crc_run;
	logic [7:0] node_byte;
	logic [7:0] addr_byte;
	logic [31:0] data_word;
	logic [3:0] tx_bit;
	logic [2:0] tx_idx;
	logic [7:0] reply [0:7];
	logic wr_strobe;
	logic is_write;
	logic [2:0] last_idx;
	logic frame_good;
	logic [15:0] sync_bits;
	logic [31:0] read_data;
	logic [7:0] reply_crc;
	logic [6:0] delay_bits;
	swu_global_cfg_t global_configuration;
	logic [3:0] reply_delay_setting;
	logic otp_loaded;

	assign fall = line_prev & ~uart_in;
	assign is_write = (addr_byte & `SWU_WRITE_OFFSET) != 8'h00;
	assign last_idx = is_write ? `SWU_LAST_WRITE : `SWU_LAST_READ;
	// own node only, and checksum over all preceding bytes
	assign frame_good = (crc_run == rx_byte) && (node_byte == `SWU_NODE_ADDR);
	assign sync_bits = meas[17:2] + 16'h0001;
	// reply delay: settings pair up to odd multiples of eight bit times
	assign delay_bits = {reply_delay_setting[3:1], 1'b1, 3'h0};

	always_comb
	begin
		read_data = 32'h0000_0000;
		unique case (addr_byte[6:0])
			`SWU_REG_GLOBAL_CFG: read_data = {22'h00_0000, global_configuration};
			`SWU_REG_WRITE_COUNT: read_data = {24'h00_0000, datagram_count};
			default: read_data = 32'h0000_0000;
		endcase
	end

	always_comb
	begin
		reply_crc = 8'h00;
		reply_crc = crc_byte(reply_crc, `SWU_SYNC_BYTE);
		reply_crc = crc_byte(reply_crc, `SWU_MASTER_ADDR);
		reply_crc = crc_byte(reply_crc, addr_byte);
		reply_crc = crc_byte(reply_crc, read_data[31:24]);
		reply_crc = crc_byte(reply_crc, read_data[23:16]);
		reply_crc = crc_byte(reply_crc, read_data[15:8]);
		reply_crc = crc_byte(reply_crc, read_data[7:0]);
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			line_prev <= 1'b1;
		else
			line_prev <= uart_in;
	end

	// ****************************************
	// link sequencer
	// ****************************************
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state <= LS_IDLE;
			sync_edge <= 1'b0;
			bit_time <= `SWU_DEFAULT_BIT_CLKS;
			cnt <= 16'h0000;
			bcnt <= 7'h00;
			meas <= 22'h00_0000;
			bit_idx <= 3'h0;
			byte_idx <= 3'h0;
			rx_byte <= 8'h00;
			crc_run <= 8'h00;
			node_byte <= 8'h00;
			addr_byte <= 8'h00;
			data_word <= 32'h0000_0000;
			tx_bit <= 4'h0;
			tx_idx <= 3'h0;
			uart_out <= 1'b1;
			uart_oe <= 1'b0;
			wr_strobe <= 1'b0;
			for (int k = 0; k < 8; k++)
				reply[k] <= 8'h00;
		end
		else
		begin
			wr_strobe <= 1'b0;
			unique case (state)
				LS_IDLE:
				begin
					if (fall)
					begin
						state <= LS_SYNC;
						meas <= 22'h00_0000;
						sync_edge <= 1'b0;
						crc_run <= 8'h00;
						byte_idx <= 3'h0;
					end
				end
				LS_SYNC:
				begin
					meas <= meas + 22'h00_0001;
					if (fall && !sync_edge)
						sync_edge <= 1'b1;
					else if (fall)
					begin
						// third falling edge closes four bit times
						if (sync_bits < `SWU_MIN_BIT_CLKS)
						begin
							state <= LS_RECOVER;
							bcnt <= `SWU_RECOVER_BITS - 7'h01;
							cnt <= bit_wait(bit_time, 1'b0);
						end
						else
						begin
							bit_time <= sync_bits;
							cnt <= bit_wait(sync_bits, 1'b1);
							bit_idx <= `SWU_SYNC_FIRST_BIT;
							rx_byte <= `SWU_SYNC_BYTE;
							state <= LS_BIT;
						end
					end
					// give up before the measured bit time would overflow
					else if (meas[18])
						state <= LS_IDLE;
				end
				LS_START:
				begin
					if (cnt != 16'h0000)
						cnt <= cnt - 16'h0001;
					else if (uart_in)
					begin
						// short pulse on the idle line
						state <= LS_RECOVER;
						bcnt <= `SWU_RECOVER_BITS - 7'h01;
						cnt <= bit_wait(bit_time, 1'b0);
					end
					else
					begin
						bit_idx <= 3'h0;
						cnt <= bit_wait(bit_time, 1'b0);
						state <= LS_BIT;
					end
				end
				LS_BIT:
				begin
					if (cnt != 16'h0000)
						cnt <= cnt - 16'h0001;
					else
					begin
						rx_byte[bit_idx] <= uart_in;
						cnt <= bit_wait(bit_time, 1'b0);
						if (bit_idx == 3'h7)
							state <= LS_STOP;
						else
							bit_idx <= bit_idx + 3'h1;
					end
				end
				LS_STOP:
				begin
					if (cnt != 16'h0000)
						cnt <= cnt - 16'h0001;
					else if (!uart_in)
					begin
						state <= LS_RECOVER;
						bcnt <= `SWU_RECOVER_BITS - 7'h01;
						cnt <= bit_wait(bit_time, 1'b0);
					end
					else if (byte_idx >= 3'h3 && byte_idx == last_idx)
					begin
						if (!frame_good)
						begin
							state <= LS_RECOVER;
							bcnt <= `SWU_RECOVER_BITS - 7'h01;
							cnt <= bit_wait(bit_time, 1'b0);
						end
						else if (is_write)
						begin
							wr_strobe <= 1'b1;
							state <= LS_IDLE;
						end
						else
						begin
							reply[0] <= `SWU_SYNC_BYTE;
							reply[1] <= `SWU_MASTER_ADDR;
							reply[2] <= addr_byte;
							reply[3] <= read_data[31:24];
							reply[4] <= read_data[23:16];
							reply[5] <= read_data[15:8];
							reply[6] <= read_data[7:0];
							reply[7] <= reply_crc;
							cnt <= bit_wait(bit_time, 1'b1);
							bcnt <= delay_bits;
							state <= LS_DELAY;
						end
					end
					else
					begin
						crc_run <= crc_byte(crc_run, rx_byte);
						if (byte_idx == 3'h1)
							node_byte <= rx_byte;
						else if (byte_idx == 3'h2)
							addr_byte <= rx_byte;
						else if (byte_idx != 3'h0)
							data_word <= {data_word[23:0], rx_byte};
						byte_idx <= byte_idx + 3'h1;
						meas <= 22'h00_0000;
						state <= LS_GAP;
					end
				end
				LS_GAP:
				begin
					meas <= meas + 22'h00_0001;
					if (fall)
					begin
						cnt <= bit_wait(bit_time, 1'b1);
						state <= LS_START;
					end
					else if (meas > {bit_time, 6'h00})
						state <= LS_IDLE;
				end
				LS_DELAY:
				begin
					if (cnt != 16'h0000)
						cnt <= cnt - 16'h0001;
					else if (bcnt != 7'h00)
					begin
						bcnt <= bcnt - 7'h01;
						cnt <= bit_wait(bit_time, 1'b0);
					end
					else
					begin
						uart_oe <= 1'b1;
						uart_out <= 1'b0;
						tx_bit <= 4'h0;
						tx_idx <= 3'h0;
						cnt <= bit_wait(bit_time, 1'b0);
						state <= LS_TX;
					end
				end
				LS_TX:
				begin
					if (cnt != 16'h0000)
						cnt <= cnt - 16'h0001;
					else
					begin
						cnt <= bit_wait(bit_time, 1'b0);
						if (tx_bit == 4'h9)
						begin
							if (tx_idx == `SWU_LAST_REPLY)
							begin
								bcnt <= `SWU_RELEASE_BITS - 7'h01;
								state <= LS_RELEASE;
							end
							else
							begin
								tx_idx <= tx_idx + 3'h1;
								tx_bit <= 4'h0;
								uart_out <= 1'b0;
							end
						end
						else
						begin
							tx_bit <= tx_bit + 4'h1;
							uart_out <= (tx_bit == 4'h8) ? 1'b1 : reply[tx_idx][tx_bit[2:0]];
						end
					end
				end
				LS_RELEASE:
				begin
					if (cnt != 16'h0000)
						cnt <= cnt - 16'h0001;
					else if (bcnt != 7'h00)
					begin
						bcnt <= bcnt - 7'h01;
						cnt <= bit_wait(bit_time, 1'b0);
					end
					else
					begin
						uart_oe <= 1'b0;
						state <= LS_IDLE;
					end
				end
				LS_RECOVER:
				begin
					// the line must stay idle for the whole recovery time
					if (!uart_in)
					begin
						bcnt <= `SWU_RECOVER_BITS - 7'h01;
						cnt <= bit_wait(bit_time, 1'b0);
					end
					else if (cnt != 16'h0000)
						cnt <= cnt - 16'h0001;
					else if (bcnt != 7'h00)
					begin
						bcnt <= bcnt - 7'h01;
						cnt <= bit_wait(bit_time, 1'b0);
					end
					else
						state <= LS_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// register bank
	// ****************************************
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			global_configuration <= `SWU_GLOBAL_CFG_RESET;
			otp_loaded <= 1'b0;
		end
		else if (wr_strobe && addr_byte[6:0] == `SWU_REG_GLOBAL_CFG)
		begin
			global_configuration <= data_word[9:0];
			otp_loaded <= 1'b1;
		end
		else if (!otp_loaded)
		begin
			global_configuration.internal_sense_resistor_select <= otp_internal_sense;
			global_configuration.chopper_mode_select <= otp_chopper_mode;
			otp_loaded <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			reply_delay_setting <= `SWU_REPLY_DELAY_RESET;
		else if (wr_strobe && addr_byte[6:0] == `SWU_REG_REPLY_DELAY)
			reply_delay_setting <= data_word[`SWU_DLY_MSB:`SWU_DLY_LSB];
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			datagram_count <= `SWU_WRITE_COUNT_RESET;
		else if (wr_strobe)
			datagram_count <= datagram_count + 8'h01;
	end

	// ****************************************
	// driver control
	// ****************************************
	swu_cfg_apply u_cfg (
		.clk(clk),
		.resetn(resetn),
		.cfg(global_configuration),
		.chopper_invert_pin(chopper_invert_pin),
		.dir_in(dir_in),
		.pin_level(uart_in),
		.first_microstep(first_microstep),
		.overtemp_prewarning(overtemp_prewarning),
		.pulse_gen_step(pulse_gen_step),
		.drive(drive),
		.index_out(index_out)
	);
endmodule

// ==== testbench/swu_uart_node_chk.sv ====
// assertions on the serial node ports
`timescale 1ns/10ps
module swu_uart_node_chk (
	input wire logic clk,
	input wire logic resetn,
	input wire logic uart_in,
	input wire logic uart_out,
	input wire logic uart_oe,
	input wire logic chopper_invert_pin,
	input wire logic dir_in,
	input swu_pkg::swu_drive_t drive,
	input wire logic [7:0] datagram_count
);
	import swu_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_idle_high: assert property (!uart_oe |-> uart_out)
		else $error("line low while released");
	a_start_bit: assert property ($rose(uart_oe) |-> !uart_out [*8])
		else $error("reply start bit too short");
	a_release_tail: assert property ($fell(uart_oe) |-> $past(uart_out, 8) && $past(uart_oe, 8))
		else $error("driver released without high tail");
	a_sense_ground: assert property (drive.internal_sense == drive.reference_pin_to_ground)
		else $error("sense and ground select differ");
	a_test_enable: assert property (drive.analog_test == drive.driver_forced_enable)
		else $error("test output and forced enable differ");
	a_dir_follow: assert property ($changed(dir_in) |=> $changed(drive.motor_dir))
		else $error("direction not followed");
	a_chop_invert: assert property ($changed(chopper_invert_pin) |=> $changed(drive.cycle_chopper))
		else $error("chopper pin not applied");
	a_pin_standby: assert property (drive.standstill_from_pin |-> $past(uart_in))
		else $error("standstill from low line");
	a_count_step: assert property ($changed(datagram_count) |-> datagram_count == $past(datagram_count) + 8'h01)
		else $error("counter jumped");
	a_count_read: assert property (uart_oe |-> $stable(datagram_count))
		else $error("counter moved during reply");
endmodule

bind swu_uart_node swu_uart_node_chk chk (.clk(clk), .resetn(resetn), .uart_in(uart_in),
	.uart_out(uart_out), .uart_oe(uart_oe), .chopper_invert_pin(chopper_invert_pin),
	.dir_in(dir_in), .drive(drive), .datagram_count(datagram_count));

// ==== testbench/swu_host.sv ====
// host side serial model on the shared line
`timescale 1ns/10ps
module swu_host #(parameter int BIT_CLKS = 20) (
	input wire logic clk,
	input wire logic line,
	output logic tx
);
	logic [7:0] pkt[$];
	logic [7:0] rx_q[$];
	logic [7:0] crc_flip = 8'h00;
	logic tmo = 1'b0;
	// the node byte is whatever pkt holds; the bench also writes to node 01
	initial tx = 1'b1;
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
		for (int i = 0; i < 8; i++)
			c = (c[7] ^ b[i]) ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
		return c;
	endfunction
	task automatic send();
		logic [7:0] c;
		c = 8'h00;
		foreach (pkt[k]) c = crc8(c, pkt[k]);
		pkt.push_back(c ^ crc_flip);
		foreach (pkt[k])
		begin
			// start, eight data bits, stop; tx stays high after
			for (int i = 0; i < 10; i++)
			begin
				@(posedge clk);
				tx <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : pkt[k][i - 1];
				repeat (BIT_CLKS - 1) @(posedge clk);
			end
		end
	endtask
	// listening starts after sending, so own echo is never kept
	task automatic recv(input int n);
		int w;
		logic [7:0] b;
		rx_q.delete();
		tmo = 1'b0;
		repeat (n)
		begin
			w = 0;
			while (line && w < 5000)
			begin
				@(posedge clk);
				w++;
			end
			if (w >= 5000)
				tmo = 1'b1;
			repeat (BIT_CLKS + BIT_CLKS / 2) @(posedge clk);
			for (int i = 0; i < 8; i++)
			begin
				b[i] = line;
				repeat (BIT_CLKS) @(posedge clk);
			end
			rx_q.push_back(b);
		end
	endtask
endmodule

// ==== testbench/single_wire_uart_global_config_tb.sv ====
// self-checking bench of the serial node and its configuration
`timescale 1ns/10ps
module single_wire_uart_global_config_tb;
	import swu_pkg::*;
	localparam int B = 20;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic chop_pin = 1'b0;
	logic dir_in = 1'b0;
	logic first_ms = 1'b0;
	logic otpw = 1'b0;
	logic pstep = 1'b0;
	logic tx, uart_out, uart_oe, index_out;
	logic [7:0] datagram_count;
	logic [31:0] rdata;
	swu_drive_t drive;
	wire line;
	int n_errors = 0;
	int compares = 0;
	int lat;
	assign line = uart_oe ? uart_out : tx;
	always #25 clk = ~clk;
	swu_host #(.BIT_CLKS(B)) host (.clk(clk), .line(line), .tx(tx));
	swu_uart_node dut (.clk(clk), .resetn(resetn), .uart_in(line), .uart_out(uart_out),
		.uart_oe(uart_oe), .otp_internal_sense(1'b1), .otp_chopper_mode(1'b1),
		.chopper_invert_pin(chop_pin), .dir_in(dir_in), .first_microstep(first_ms),
		.overtemp_prewarning(otpw), .pulse_gen_step(pstep), .drive(drive),
		.index_out(index_out), .datagram_count(datagram_count));
	// ****************************************
	// helpers
	// ****************************************
	task automatic conclude();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	function automatic swu_drive_t exp_drive(input logic [9:0] g);
		return {g[0], g[1], g[1], g[2] ^ chop_pin, dir_in ^ g[3], ~g[6], g[7], g[8], g[9], g[9]};
	endfunction
	task automatic wr(input logic [7:0] node, input logic [7:0] a, input logic [31:0] d);
		host.pkt = {8'h05, node, a, d[31:24], d[23:16], d[15:8], d[7:0]};
		host.send();
		tick(4);
	endtask
	task automatic rd(input logic [7:0] a, input int n);
		logic [7:0] c;
		host.pkt = {8'h05, 8'h00, a};
		host.send();
		fork
			host.recv(8);
			begin
				lat = 0;
				while (!uart_oe && lat < 5000)
				begin
					@(posedge clk);
					lat++;
				end
			end
		join
		tick(6 * B);
		check("timeout", host.tmo, 0);
		if (host.tmo)
			conclude();
		check("reply_delay", lat > n * B - 5 && lat < n * B + 5, 1);
		check("sync", host.rx_q[0], 8'h05);
		check("dest", host.rx_q[1], 8'hFF);
		check("reg", host.rx_q[2], a);
		c = 8'h00;
		for (int i = 0; i < 7; i++)
			c = host.crc8(c, host.rx_q[i]);
		check("crc", host.rx_q[7], c);
		rdata = {host.rx_q[3], host.rx_q[4], host.rx_q[5], host.rx_q[6]};
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		check("drive", drive, exp_drive(10'h107));
		rd(8'h00, 8);
		check("global_configuration", rdata, 32'h107);
		check("count", datagram_count, 0);
	endtask
	task automatic t_global_configuration();
		for (int i = 0; i < 10; i++)
		begin
			wr(8'h00, 8'h80, 32'h1 << i);
			check("drive", drive, exp_drive(10'h1 << i));
			check("count", datagram_count, i + 1);
		end
		@(posedge clk);
		chop_pin <= 1'b1;
		dir_in <= 1'b1;
		tick(3);
		check("drive", drive, exp_drive(10'h200));
		rd(8'h00, 8);
		check("global_configuration", rdata, 32'h200);
		rd(8'h02, 8);
		check("count", rdata, 32'hA);
	endtask
	task automatic t_refuse();
		host.crc_flip = 8'h01;
		wr(8'h00, 8'h80, 32'h1);
		host.crc_flip = 8'h00;
		tick(13 * B);
		wr(8'h01, 8'h80, 32'h1);
		tick(13 * B);
		check("count", datagram_count, 8'hA);
		check("drive", drive, exp_drive(10'h200));
	endtask
	task automatic t_index();
		logic v;
		wr(8'h00, 8'h80, 32'h0);
		@(posedge clk);
		first_ms <= 1'b1;
		tick(3);
		check("index", index_out, 1);
		wr(8'h00, 8'h80, 32'h10);
		check("index", index_out, 0);
		@(posedge clk);
		otpw <= 1'b1;
		tick(3);
		check("index", index_out, 1);
		wr(8'h00, 8'h80, 32'h30);
		v = index_out;
		@(posedge clk);
		pstep <= 1'b1;
		@(posedge clk);
		pstep <= 1'b0;
		tick(3);
		check("index", index_out, !v);
	endtask
	initial
	begin
		tick(2);
		resetn <= 1'b1;
		tick(4);
		t_reset();
		t_global_configuration();
		t_refuse();
		t_index();
		wr(8'h00, 8'h83, 32'h300);
		rd(8'h00, 24);
		check("global_configuration", rdata, 32'h30);
		conclude();
	end
endmodule
